// >>> hw/icc_ctrl.sv
// Control register of the two-wire bus controller with its byte-wide host bus slave
//
// Overview of operation
// - Only with the enable bit set do the other control bits act on the controller.
// - While the enable bit is clear the serial engine is held in reset and disabled.
// - The interrupt request is raised only while the gate bit and the pending flag are both set.
// - Clearing the gate bit masks the request but leaves the pending flag untouched.
// - A rising master select bit issues a START and makes the controller master.
// - A cleared master select bit issues a STOP and returns to slave operation.
// - When master select is cleared by lost arbitration no STOP is issued.
// - The transmit select bit sets direction, 1 transmit and 0 receive.
// - On a receive acknowledge cycle the data line carries the acknowledge select bit.
// - Writing 1 to repeat start issues a repeated START when the controller owns the bus.
// - A repeated START asked for while another master owns the bus counts as lost arbitration.
// - The pending flag is set by hardware events and cleared by software writing 0.
// - The arbitration-lost flag is set on lost arbitration and cleared by software writing 0.
`include "icc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module icc_ctrl (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Host bus
  input  wire logic [23:0] addrBus,
  input  wire logic [7:0]  dataIn,
  output logic      [7:0]  dataOut,
  output logic             dataOe,
  input  wire logic        addrStrobe_n,
  input  wire logic        dataStrobe_n,
  input  wire logic        readNotWrite,
  output logic             dtack_n,
  output logic             irq_n,
  // Serial engine side
  input  wire logic        pendingEvent,
  input  wire logic        arbLostEvent,
  input  wire logic        busBusy,
  input  wire logic        ackCycle,
  input  wire logic        receiving,
  output logic             engineRst,
  output logic             startReq,
  output logic             stopReq,
  output logic             repStartReq,
  output logic             masterMode,
  output logic             transmitMode,
  output logic             ackDrive,
  output logic             ackDriveEn
);
  logic [2:0] syncStb;
  logic       as_n, ds_n, rnw;
  icc_pkg::icc_bus_t busState;
  logic [7:0] ctrl;
  logic       pendFlag, alostFlag, mselPrev;
  logic       hit, selCtrl, selStat, wrStb;
  logic       foreignRep;
  logic [31:0] busSync;
  logic [23:0] addrSync;
  logic [7:0]  dataSync;

  // Strobes pass inverted so the synchroniser's reset value reads as idle
  icc_sync #(.W(3)) uSync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  ({!addrStrobe_n, !dataStrobe_n, readNotWrite}),
    .syncOut  (syncStb)
  );
  // Address and data take the strobes' latency so they line up with them
  icc_sync #(.W(32)) uSyncBus (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  ({addrBus, dataIn}),
    .syncOut  (busSync)
  );
  assign as_n     = !syncStb[2];
  assign ds_n     = !syncStb[1];
  assign rnw      = syncStb[0];
  assign addrSync = busSync[31:8];
  assign dataSync = busSync[7:0];

  function automatic logic regHit(input logic [23:0] a, input logic [7:0] off);
    regHit = (a[23:8] == `ICC_BASE_ADDR) && (a[7:0] == off);
  endfunction : regHit

  assign selCtrl = regHit(addrSync, `ICC_ADDR_CTRL);
  assign selStat = regHit(addrSync, `ICC_ADDR_STAT);
  assign hit     = selCtrl | selStat;
  assign wrStb   = (busState == icc_pkg::BUS_XFER) && !rnw;
  assign foreignRep = ctrl[`ICC_BIT_EN] && wrStb && selCtrl && dataSync[`ICC_BIT_RSTART]
                      && !ctrl[`ICC_BIT_MSEL] && busBusy;

  // Host bus handshake
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busState <= icc_pkg::BUS_IDLE;
    end else begin
      unique case (busState)
        icc_pkg::BUS_IDLE:  if (!as_n) busState <= icc_pkg::BUS_ADDR;
        icc_pkg::BUS_ADDR: begin
          if (as_n) busState <= icc_pkg::BUS_IDLE;
          else if (hit && !ds_n) busState <= icc_pkg::BUS_XFER;
        end
        icc_pkg::BUS_XFER:  busState <= icc_pkg::BUS_DTACK;
        icc_pkg::BUS_DTACK: if (as_n && ds_n) busState <= icc_pkg::BUS_IDLE;
      endcase
    end
  end
  assign dtack_n = !(busState == icc_pkg::BUS_DTACK);

  // Control register, reserved and repeat start bits not stored
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= `ICC_CTRL_RESET;
    end else if (wrStb && selCtrl) begin
      ctrl <= dataSync & `ICC_CTRL_WMASK;
    end else if (arbLostEvent || !ctrl[`ICC_BIT_EN]) begin
      ctrl[`ICC_BIT_MSEL] <= 1'b0;
    end
  end

  // Read data held in a flop
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataOut <= 8'h00;
    end else if (busState == icc_pkg::BUS_XFER && rnw) begin
      if (selCtrl) dataOut <= {ctrl[7:3], 3'b000};
      else dataOut <= {3'b000, alostFlag, 2'b00, pendFlag, 1'b0};
    end
  end
  assign dataOe = rnw && (busState == icc_pkg::BUS_XFER || busState == icc_pkg::BUS_DTACK);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pendFlag <= 1'b0;
    end else if (!ctrl[`ICC_BIT_EN]) begin
      pendFlag <= 1'b0;
    end else if (pendingEvent) begin
      pendFlag <= 1'b1;
    end else if (wrStb && selStat && !dataSync[`ICC_BIT_PEND]) begin
      pendFlag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alostFlag <= 1'b0;
    end else if (!ctrl[`ICC_BIT_EN]) begin
      alostFlag <= 1'b0;
    end else if (arbLostEvent || foreignRep) begin
      alostFlag <= 1'b1;
    end else if (wrStb && selStat && !dataSync[`ICC_BIT_ALOST]) begin
      alostFlag <= 1'b0;
    end
  end

  // Start and stop edge detection
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mselPrev    <= 1'b0;
      startReq    <= 1'b0;
      stopReq     <= 1'b0;
      repStartReq <= 1'b0;
    end else begin
      mselPrev    <= ctrl[`ICC_BIT_MSEL];
      startReq    <= ctrl[`ICC_BIT_EN] && ctrl[`ICC_BIT_MSEL] && !mselPrev;
      stopReq     <= ctrl[`ICC_BIT_EN] && !ctrl[`ICC_BIT_MSEL] && mselPrev && !arbLostEvent
                     && !alostFlag;
      repStartReq <= ctrl[`ICC_BIT_EN] && wrStb && selCtrl && dataSync[`ICC_BIT_RSTART]
                     && ctrl[`ICC_BIT_MSEL];
    end
  end

  assign engineRst    = !ctrl[`ICC_BIT_EN];
  assign masterMode   = ctrl[`ICC_BIT_EN] && ctrl[`ICC_BIT_MSEL];
  assign transmitMode = ctrl[`ICC_BIT_EN] && ctrl[`ICC_BIT_TXSEL];
  // Acknowledge value, relies on software setting it
  assign ackDrive     = ctrl[`ICC_BIT_ACKSEL];
  assign ackDriveEn   = ctrl[`ICC_BIT_EN] && ackCycle && receiving && !ctrl[`ICC_BIT_ACKSEL];
  assign irq_n        = !(ctrl[`ICC_BIT_EN] && ctrl[`ICC_BIT_IEN] && pendFlag);

  property p_irq;
    @(posedge core_clk) disable iff (sys_rst)
      (!irq_n) |-> (pendFlag && ctrl[`ICC_BIT_IEN]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without flag and gate");

  property p_keep;
    @(posedge core_clk) disable iff (sys_rst)
      ($fell(ctrl[`ICC_BIT_IEN]) && ctrl[`ICC_BIT_EN] && $past(ctrl[`ICC_BIT_EN])
       && $past(pendFlag)) |-> pendFlag;
  endproperty
  a_keep: assert property (p_keep) else $error("gate clear lost flag");

  sequence s_rise;
    ctrl[`ICC_BIT_EN] && ctrl[`ICC_BIT_MSEL] && !mselPrev;
  endsequence
  property p_start;
    @(posedge core_clk) disable iff (sys_rst) s_rise |=> startReq;
  endproperty
  a_start: assert property (p_start) else $error("no start on select rise");

  property p_nostop;
    @(posedge core_clk) disable iff (sys_rst) arbLostEvent |=> (!stopReq) [*2];
  endproperty
  a_nostop: assert property (p_nostop) else $error("stop after lost arbitration");

  property p_rd0;
    @(posedge core_clk) disable iff (sys_rst)
      (busState == icc_pkg::BUS_DTACK && rnw && selCtrl) |-> (dataOut[2:0] == 3'b000);
  endproperty
  a_rd0: assert property (p_rd0) else $error("low control bits read nonzero");

  property p_dis;
    @(posedge core_clk) disable iff (sys_rst)
      engineRst |-> (!masterMode && !transmitMode && irq_n && !ackDriveEn);
  endproperty
  a_dis: assert property (p_dis) else $error("disabled controller acts");

  property p_pend;
    @(posedge core_clk) disable iff (sys_rst)
      (pendingEvent && ctrl[`ICC_BIT_EN] && !(wrStb && selCtrl)) |=> pendFlag;
  endproperty
  a_pend: assert property (p_pend) else $error("pending event lost");

  property p_alost;
    @(posedge core_clk) disable iff (sys_rst)
      (arbLostEvent && ctrl[`ICC_BIT_EN] && !(wrStb && selCtrl)) |=> alostFlag;
  endproperty
  a_alost: assert property (p_alost) else $error("arbitration loss lost");
endmodule : icc_ctrl
`default_nettype wire

// >>> hw/icc_defs.svh
// Offsets, field positions, reset value and write mask of the control register block
`ifndef ICC_DEFS_SVH
`define ICC_DEFS_SVH
`define ICC_ADDR_CTRL     8'h8F
`define ICC_ADDR_STAT     8'h93
`define ICC_BASE_ADDR     16'h0000
`define ICC_BIT_EN        7
`define ICC_BIT_IEN       6
`define ICC_BIT_MSEL      5
`define ICC_BIT_TXSEL     4
`define ICC_BIT_ACKSEL    3
`define ICC_BIT_RSTART    2
`define ICC_BIT_ALOST     4
`define ICC_BIT_PEND      1
`define ICC_CTRL_RESET    8'h00
`define ICC_CTRL_WMASK    8'hF8
`endif

// >>> hw/icc_pkg.sv
// Types of the control register block
package icc_pkg;
  typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_XFER, BUS_DTACK} icc_bus_t;
endpackage : icc_pkg

// >>> hw/icc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module icc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule : icc_sync
`default_nettype wire

// >>> test/icc_engine_model.sv
// Serial engine stand-in that turns bench requests into one-cycle event pulses
`timescale 1ns/100ps
`default_nettype none
module icc_engine_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Requests from the bench
  input  wire logic reqPend,
  input  wire logic reqArb,
  // Events to the controller
  output logic      pendingEvent,
  output logic      arbLostEvent
);
  // hardware-set events
  // A held request gives a one-cycle pulse on every other cycle, as the real engine would
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pendingEvent <= 1'h0;
      arbLostEvent <= 1'h0;
    end else begin
      pendingEvent <= reqPend & ~pendingEvent;
      arbLostEvent <= reqArb & ~arbLostEvent;
    end
  end
endmodule : icc_engine_model
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the control register block
`include "icc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        core_clk, sys_rst, addrStrobe_n, dataStrobe_n, readNotWrite, reqPend, reqArb;
  logic        busBusy, ackCycle, receiving, dataOe, dtack_n, irq_n, engineRst, startReq;
  logic        stopReq, repStartReq, masterMode, transmitMode, ackDrive, ackDriveEn;
  logic        pendingEvent, arbLostEvent, acked;
  logic [23:0] addrBus;
  logic [7:0]  dataIn, dataOut, rd, v;
  int          num_errors, compares, nStart, nStop, nRep, seed, n0;
  icc_ctrl dut_u (.*);
  icc_engine_model eng_u (.*);
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (startReq === 1'h1) nStart++;
    if (stopReq === 1'h1) nStop++;
    if (repStartReq === 1'h1) nRep++;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // Holds the cycle until acknowledge, or gives up after a bounded wait
  task automatic acc(input logic [7:0] a, input logic rnw, input logic [7:0] w, input bit want);
    int n;
    @(posedge core_clk);
    addrBus <= {16'h0000, a};
    readNotWrite <= rnw;
    dataIn <= w;
    addrStrobe_n <= 1'h0;
    dataStrobe_n <= 1'h0;
    n = 0;
    // Acknowledge and read data are taken at the edge that sees acknowledge low
    do @(posedge core_clk); while (dtack_n !== 1'h0 && ++n < 20);
    acked = (dtack_n === 1'h0);
    rd = dataOut;
    if (want && !acked) begin
      num_errors++;
      conclude();
    end
    addrStrobe_n <= 1'h1;
    dataStrobe_n <= 1'h1;
    n = 0;
    do @(posedge core_clk); while (dtack_n !== 1'h1 && ++n < 20);
    if (n >= 20) begin
      num_errors++;
      conclude();
    end
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(a, 1'h0, d, 1);
    repeat (6) @(posedge core_clk);
  endtask : wr
  task automatic ev(input bit arb);
    @(posedge core_clk);
    reqArb <= arb;
    reqPend <= !arb;
    @(posedge core_clk);
    reqArb <= 1'h0;
    reqPend <= 1'h0;
    repeat (3) @(negedge core_clk);
  endtask : ev
  initial begin
    {num_errors, compares, nStart, nStop, nRep} = '0;
    seed = 48;
    {sys_rst, addrStrobe_n, dataStrobe_n, readNotWrite} = 4'h0 | 4'hF;
    {addrBus, dataIn, reqPend, reqArb, busBusy, ackCycle, receiving} = '0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'h0;
    acc(`ICC_ADDR_CTRL, 1'h1, 8'h00, 1);
    chk("ctrl reset", rd, `ICC_CTRL_RESET);
    chk("engineRst", engineRst, 8'h01);
    {ackCycle, receiving} <= 2'h3;
    for (int i = 0; i < 6; i++) begin
      v = 8'(($random(seed) & 8'hDF) | 8'h80);
      wr(`ICC_ADDR_CTRL, v);
      acc(`ICC_ADDR_CTRL, 1'h1, 8'h00, 1);
      chk("ctrl readback", rd, v & 8'hF8);
      chk("transmitMode", transmitMode, v[4]);
      chk("ackDrive", {ackDrive, ackDriveEn}, {v[3], !v[3]});
    end
    $display("Test fields done");
    wr(`ICC_ADDR_CTRL, 8'h80);
    n0 = nStart;
    wr(`ICC_ADDR_CTRL, 8'hA0);
    chk("starts", nStart - n0, 8'h01);
    chk("masterMode", masterMode, 8'h01);
    wr(`ICC_ADDR_CTRL, 8'hA8);
    chk("last byte nack", {ackDrive, ackDriveEn}, 8'h02);
    wr(`ICC_ADDR_CTRL, 8'hA4);
    chk("repeats", nRep, 8'h01);
    n0 = nStop;
    wr(`ICC_ADDR_CTRL, 8'h80);
    chk("stops", nStop - n0, 8'h01);
    chk("slave", masterMode, 8'h00);
    $display("Test master done");
    wr(`ICC_ADDR_CTRL, 8'hC0);
    ev(0);
    chk("irq gated on", irq_n, 8'h00);
    wr(`ICC_ADDR_CTRL, 8'h80);
    chk("irq masked", irq_n, 8'h01);
    acc(`ICC_ADDR_STAT, 1'h1, 8'h00, 1);
    chk("pending kept", rd[1], 8'h01);
    wr(`ICC_ADDR_STAT, 8'h00);
    acc(`ICC_ADDR_STAT, 1'h1, 8'h00, 1);
    chk("pending cleared", rd[1], 8'h00);
    $display("Test interrupt done");
    wr(`ICC_ADDR_CTRL, 8'hA0);
    n0 = nStop;
    ev(1);
    acc(`ICC_ADDR_STAT, 1'h1, 8'h00, 1);
    chk("arb lost", rd[4], 8'h01);
    wr(`ICC_ADDR_CTRL, 8'h80);
    chk("no stop", nStop - n0, 8'h00);
    wr(`ICC_ADDR_STAT, 8'h00);
    busBusy <= 1'h1;
    n0 = nRep;
    wr(`ICC_ADDR_CTRL, 8'h84);
    acc(`ICC_ADDR_STAT, 1'h1, 8'h00, 1);
    chk("foreign repeat", {rd[4], 7'(nRep - n0)}, 8'h80);
    busBusy <= 1'h0;
    $display("Test arbitration done");
    n0 = nStart;
    wr(`ICC_ADDR_CTRL, 8'h70);
    chk("disabled", {engineRst, masterMode, 6'(nStart - n0)}, 8'h80);
    acc(8'h42, 1'h1, 8'h00, 0);
    chk("unmapped", acked, 8'h00);
    $display("Test disable done");
    conclude();
  end
  initial begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule : tb
`default_nettype wire
